// *** mgmt_cfg.svh ***
// Offsets, field positions, size codes and opcodes for the management-mode unit
`ifndef MGMT_CFG_SVH
`define MGMT_CFG_SVH

// APB register byte addresses
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_CORE_STATE  8'h08
`define OFF_TRAP_INFO   8'h0c
`define OFF_TRAP_ADDR   8'h10
`define OFF_TRAP_DATA   8'h14
`define OFF_TRAP_INDEX  8'h18
`define OFF_OPCODE      8'h1c
`define OFF_REGION      8'h20

// Header offsets below the top of management memory
`define HDR_DEBUG7      8'h04
`define HDR_FLAGS       8'h08
`define HDR_CTRL0       8'h0c
`define HDR_CUR_IP      8'h10
`define HDR_NEXT_IP     8'h14
`define HDR_CS_SEL      8'h18
`define HDR_CS_DESC_HI  8'h1c
`define HDR_CS_DESC_LO  8'h20
`define HDR_STATUS      8'h24
`define HDR_IO_INFO     8'h28
`define HDR_DATA        8'h2c
`define HDR_INDEX       8'h30
`define HDR_MEM_ADDR    8'h34
`define HDR_WORDS       13

// Status word bit positions in the header
`define BIT_C           0
`define BIT_I           1
`define BIT_P           2
`define BIT_S           3
`define BIT_H           4
`define BIT_M           5
`define BIT_X           6
`define BIT_V           7
`define BIT_N           8

// I/O size codes
`define SIZE_BYTE       16'h0001
`define SIZE_WORD       16'h0003
`define SIZE_DWORD      16'h000f

// Opcode bytes (0f escape and the second byte after it), code segment register code and transfer bits
`define OP_SEG_SAVE     8'h78
`define OP_SEG_REST     8'h79
`define OP_LDT_SAVE     8'h7a
`define OP_LDT_REST     8'h7b
`define OP_TASK_SAVE    8'h7c
`define OP_TASK_REST    8'h7d
`define OP_SW_ENTRY     8'h38
`define OP_RESUME       8'haa
`define OP_ESCAPE       8'h0f
`define SREG_CS         3'h1
`define XFER_BITS       7'h50

`endif

// *** mgmt_pkg.sv ***
// Types shared by the management-mode unit
package mgmt_pkg;
    typedef struct packed {
        logic [31:0] debug7;
        logic [31:0] flags;
        logic [31:0] ctrl0;
        logic [31:0] cur_ip;
        logic [31:0] next_ip;
        logic [15:0] cs_sel;
        logic [63:0] cs_desc;
        logic        cs_writable;
        logic        halted;
    } core_state_type;

    typedef struct packed {
        logic        vga;
        logic        external;
        logic        is_memory;
        logic        rep_prefix;
        logic        is_write;
        logic [1:0]  size;
        logic [15:0] io_port;
        logic [31:0] data;
        logic [31:0] index;
        logic [31:0] mem_addr;
    } trap_info_type;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_SAVE   = 5'b00010,
        ST_RUN    = 5'b00100,
        ST_LOAD   = 5'b01000,
        ST_RETURN = 5'b10000
    } mode_state_type;
endpackage : mgmt_pkg

// *** mgmt_unit.sv ***
// Management-mode entry, state-save header writer and instruction checker
//
// Overview of operation
// - Save debug7, flags and ctrl0 words on entry
// - Save current and next instruction pointers
// - Save code selector and 8-byte descriptor
// - Nested-entry flag copies in_mgmt at entry; entries start only from idle, so it always reads zero
// - Flag entries caused by VGA region access
// - Flag pin entry one, internal unit zero
// - Access-type flag: zero I/O, one memory
// - Flag halt or shutdown before entry
// - Flag software-instruction entry, else clear
// - Flag repeat prefix on trapped string I/O
// - Flag I/O write one, read zero
// - Flag writable code segment
// - Store I/O size code and port
// - Store trapped data in one shared word
// - Store restored index for string repeat
// - Store trapped physical address
// - Check enables before save/restore/resume, else fault
// - Software entry needs all four enables outside
// - Defer pin interrupt until software session resumes
// - Save/restore operations transfer eighty bits
// - Segment restore on code segment faults
// - Decode 0f 78..7d, 0f 38, 0f aa
// - Header sits at top, descending offsets
// - Memory data shares the I/O data word
`timescale 1ns/10ps
`include "mgmt_cfg.svh"

module mgmt_unit (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    mgmt_interrupt_pin_n,
    input  wire logic                    internal_trap,
    input  wire mgmt_pkg::trap_info_type trap_in,
    input  wire mgmt_pkg::core_state_type core_in,
    input  wire logic [1:0]              privilege,
    input  wire logic                    op_valid,
    input  wire logic [7:0]              op_byte0,
    input  wire logic [7:0]              op_byte1,
    input  wire logic [2:0]              op_sreg,
    input  wire logic                    hdr_ready,
    output logic                         hdr_we,
    output logic      [31:0]             hdr_addr,
    output logic      [31:0]             hdr_wdata,
    output logic                         invalid_opcode,
    output logic                         op_accept,
    output logic      [6:0]              op_xfer_bits,
    output logic                         in_mgmt,
    output logic                         resume_valid,
    output logic      [31:0]             resume_ip,
    output mgmt_pkg::core_state_type     resume_state
);
    mgmt_pkg::mode_state_type state;
    mgmt_pkg::core_state_type saved_core;
    mgmt_pkg::trap_info_type  saved_trap;
    logic        mgmt_feature_enable;
    logic        mgmt_access_control;
    logic [31:0] mgmt_region_register;
    logic [31:0] header_top;
    logic        nested_flag;
    logic        sw_session;
    logic        sw_entry_flag;
    logic        pin_entry_flag;
    logic        pin_pending;
    logic        pin_sync1;
    logic        pin_sync2;
    logic        pin_prev;
    logic [3:0]  word_idx;
    logic [31:0] fault_count;
    logic [31:0] next_hdr_word;
    logic [8:0]  status_word;
    logic [15:0] size_code;
    logic        enables_ok;
    logic        is_escape;
    logic        instr_allowed;
    logic        entry_allowed;
    logic        is_save_rest;
    logic        pin_fall;
    logic        hw_request;
    logic        apb_access;

    // Pin is asynchronous: two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync1 <= 1'b1;
            pin_sync2 <= 1'b1;
            pin_prev  <= 1'b1;
        end else begin
            pin_sync1 <= mgmt_interrupt_pin_n;
            pin_sync2 <= pin_sync1;
            pin_prev  <= pin_sync2;
        end
    end

    // Shared enable conditions and opcode decode
    assign enables_ok    = mgmt_feature_enable && (mgmt_region_register[3:0] != 4'h0)
                           && (privilege == 2'b00);
    assign is_escape     = op_valid && (op_byte0 == `OP_ESCAPE);
    assign is_save_rest  = is_escape && (op_byte1 >= `OP_SEG_SAVE)
                           && (op_byte1 <= `OP_TASK_REST);
    assign instr_allowed = enables_ok && (mgmt_access_control || in_mgmt);
    assign entry_allowed = in_mgmt || (enables_ok && mgmt_access_control);
    assign pin_fall      = pin_prev && !pin_sync2;
    assign hw_request    = pin_pending || internal_trap;
    assign apb_access    = psel && penable;

    // Edge on the pin is remembered until it can be serviced
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_pending <= 1'b0;
        end else if (pin_fall) begin
            pin_pending <= 1'b1; // Set wins over a same-cycle take
        end else if (state == mgmt_pkg::ST_IDLE && !sw_session && !internal_trap
                     && !(is_escape && op_byte1 == `OP_SW_ENTRY && entry_allowed)) begin
            pin_pending <= 1'b0; // Kept if a software entry wins this cycle
        end
    end

    // Instruction checker; one-cycle answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            invalid_opcode <= 1'b0;
            op_accept      <= 1'b0;
            op_xfer_bits   <= 7'h00;
            fault_count    <= 32'h0000_0000;
        end else begin
            invalid_opcode <= 1'b0;
            op_accept      <= 1'b0;
            op_xfer_bits   <= 7'h00;
            if (is_save_rest) begin
                if (!instr_allowed) begin
                    invalid_opcode <= 1'b1;
                end else if (op_byte1 == `OP_SEG_REST && op_sreg == `SREG_CS) begin
                    invalid_opcode <= 1'b1;
                end else begin
                    op_accept    <= 1'b1;
                    op_xfer_bits <= `XFER_BITS;
                end
            end else if (is_escape && op_byte1 == `OP_RESUME && !instr_allowed) begin
                invalid_opcode <= 1'b1;
            end else if (is_escape && op_byte1 == `OP_SW_ENTRY && !entry_allowed) begin
                invalid_opcode <= 1'b1;
            end
            if ((is_save_rest || is_escape) && !instr_allowed && !entry_allowed) begin
                fault_count <= fault_count + 32'h0000_0001;
            end
        end
    end

    // Mode sequencer: entry, header save, run, resume
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= mgmt_pkg::ST_IDLE;
            in_mgmt        <= 1'b0;
            sw_session     <= 1'b0;
            sw_entry_flag  <= 1'b0;
            pin_entry_flag <= 1'b0;
            nested_flag    <= 1'b0;
            word_idx       <= 4'h0;
            saved_core     <= '0;
            saved_trap     <= '0;
            resume_valid   <= 1'b0;
            resume_ip      <= 32'h0000_0000;
            resume_state   <= '0;
        end else begin
            resume_valid <= 1'b0;
            unique case (state)
                mgmt_pkg::ST_IDLE, mgmt_pkg::ST_RUN: begin
                    if (is_escape && op_byte1 == `OP_SW_ENTRY && entry_allowed
                        && !(state == mgmt_pkg::ST_RUN)) begin
                        state         <= mgmt_pkg::ST_SAVE;
                        sw_entry_flag <= 1'b1;
                        sw_session    <= 1'b1;
                        pin_entry_flag <= 1'b0;
                        nested_flag   <= in_mgmt;
                        saved_core    <= core_in;
                        saved_trap    <= '0;
                        word_idx      <= 4'h0;
                    end else if (state == mgmt_pkg::ST_IDLE && hw_request
                                 && !sw_session) begin
                        state          <= mgmt_pkg::ST_SAVE;
                        sw_entry_flag  <= 1'b0;
                        pin_entry_flag <= !internal_trap;
                        nested_flag    <= in_mgmt;
                        saved_core     <= core_in;
                        saved_trap     <= trap_in;
                        word_idx       <= 4'h0;
                    end else if (state == mgmt_pkg::ST_RUN && is_escape
                                 && op_byte1 == `OP_RESUME && instr_allowed) begin
                        state <= mgmt_pkg::ST_LOAD;
                    end
                end
                mgmt_pkg::ST_SAVE: begin
                    if (hdr_we && hdr_ready) begin // Advance only on an accepted word
                        if (word_idx == 4'(`HDR_WORDS - 1)) begin
                            state   <= mgmt_pkg::ST_RUN;
                            in_mgmt <= 1'b1;
                        end else begin
                            word_idx <= word_idx + 4'h1;
                        end
                    end
                end
                mgmt_pkg::ST_LOAD: begin
                    resume_state <= saved_core;
                    resume_ip    <= saved_core.next_ip;
                    state        <= mgmt_pkg::ST_RETURN;
                end
                mgmt_pkg::ST_RETURN: begin
                    resume_valid <= 1'b1;
                    in_mgmt      <= nested_flag;
                    sw_session   <= 1'b0; // Frees a deferred pin request
                    state        <= mgmt_pkg::ST_IDLE;
                end
                default: begin
                    state <= mgmt_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Header status word and size code
    always_comb begin
        status_word             = 9'h000;
        status_word[`BIT_C]     = saved_core.cs_writable;
        status_word[`BIT_I]     = saved_trap.is_write;
        status_word[`BIT_P]     = saved_trap.rep_prefix;
        status_word[`BIT_S]     = sw_entry_flag;
        status_word[`BIT_H]     = saved_core.halted;
        status_word[`BIT_M]     = saved_trap.is_memory;
        status_word[`BIT_X]     = pin_entry_flag;
        status_word[`BIT_V]     = saved_trap.vga;
        status_word[`BIT_N]     = nested_flag;
        unique case (saved_trap.size)
            2'b00:   size_code = `SIZE_BYTE;
            2'b01:   size_code = `SIZE_WORD;
            default: size_code = `SIZE_DWORD;
        endcase
    end

    // Header word selected by index, top word first
    always_comb begin
        next_hdr_word = 32'h0000_0000;
        unique case (word_idx)
            4'h0:    next_hdr_word = saved_core.debug7;
            4'h1:    next_hdr_word = saved_core.flags;
            4'h2:    next_hdr_word = saved_core.ctrl0;
            4'h3:    next_hdr_word = saved_core.cur_ip;
            4'h4:    next_hdr_word = saved_core.next_ip;
            4'h5:    next_hdr_word = {16'h0000, saved_core.cs_sel};
            4'h6:    next_hdr_word = saved_core.cs_desc[63:32];
            4'h7:    next_hdr_word = saved_core.cs_desc[31:0];
            4'h8:    next_hdr_word = {23'h000000, status_word};
            4'h9:    next_hdr_word = {size_code, saved_trap.io_port};
            4'ha:    next_hdr_word = saved_trap.data; // Memory or I/O alike
            4'hb:    next_hdr_word = saved_trap.index;
            4'hc:    next_hdr_word = saved_trap.mem_addr;
            default: next_hdr_word = 32'h0000_0000;
        endcase
    end

    // Header write port; address counts down from the top
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr_we    <= 1'b0;
            hdr_addr  <= 32'h0000_0000;
            hdr_wdata <= 32'h0000_0000;
        end else if (state == mgmt_pkg::ST_SAVE && !(hdr_we && hdr_ready)) begin
            hdr_we    <= 1'b1;
            hdr_addr  <= header_top - {26'h0, word_idx, 2'b00} - 32'h0000_0004;
            hdr_wdata <= next_hdr_word;
        end else begin
            hdr_we <= 1'b0;
        end
    end

    // Header top is end of region: base plus size
    assign header_top = {mgmt_region_register[31:12], 12'h000}
                        + (32'h0000_1000 << mgmt_region_register[3:0]);

    // Writable configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mgmt_feature_enable  <= 1'b0;
            mgmt_access_control  <= 1'b0;
            mgmt_region_register <= 32'h0000_0000;
        end else if (apb_access && pwrite) begin
            if (paddr == `OFF_CTRL) begin
                mgmt_feature_enable <= pwdata[0];
                mgmt_access_control <= pwdata[1];
            end else if (paddr == `OFF_REGION) begin
                mgmt_region_register <= pwdata;
            end
        end
    end

    // APB read side; zero wait states, unmapped address errors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                unique case (paddr)
                    `OFF_CTRL:       prdata <= {30'h0, mgmt_access_control,
                                                mgmt_feature_enable};
                    `OFF_STATUS:     prdata <= {21'h0, sw_session, in_mgmt, status_word};
                    `OFF_CORE_STATE: prdata <= {27'h0, state};
                    `OFF_TRAP_INFO:  prdata <= {size_code, saved_trap.io_port};
                    `OFF_TRAP_ADDR:  prdata <= saved_trap.mem_addr;
                    `OFF_TRAP_DATA:  prdata <= saved_trap.data;
                    `OFF_TRAP_INDEX: prdata <= fault_count;
                    `OFF_OPCODE:     prdata <= {25'h0, op_xfer_bits};
                    `OFF_REGION:     prdata <= mgmt_region_register;
                    default: begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule : mgmt_unit

// *** mgmt_unit_monitor.sv ***
// Concurrent checks on the management-mode unit ports
`timescale 1ns/10ps
module mgmt_unit_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        op_valid,
    input wire logic [7:0]  op_byte0,
    input wire logic [7:0]  op_byte1,
    input wire logic [2:0]  op_sreg,
    input wire logic [1:0]  privilege,
    input wire logic        hdr_ready,
    input wire logic        hdr_we,
    input wire logic [31:0] hdr_addr,
    input wire logic        invalid_opcode,
    input wire logic        op_accept,
    input wire logic [6:0]  op_xfer_bits,
    input wire logic        resume_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Escape-prefixed decode requests
    logic esc;
    logic save_rest;
    assign esc       = op_valid && op_byte0 == 8'h0f;
    assign save_rest = esc && op_byte1 >= 8'h78 && op_byte1 <= 8'h7d;

    AST_XFER_EIGHTY: assert property (op_accept && $past(save_rest) |-> op_xfer_bits == 7'h50)
        else $error("save or restore accepted without an 80-bit transfer");
    AST_PRIV_FAULT: assert property (save_rest && privilege != 2'h0 |=> invalid_opcode && !op_accept)
        else $error("save or restore above level zero not refused");
    AST_RESUME_FAULT: assert property (esc && op_byte1 == 8'haa && privilege != 2'h0 |=> invalid_opcode ##1 !resume_valid [*3])
        else $error("resume above level zero not refused");
    AST_CS_RESTORE: assert property (esc && op_byte1 == 8'h79 && op_sreg == 3'h1 |=> !op_accept)
        else $error("segment restore into code segment accepted");
    AST_DECODE_ANSWER: assert property (save_rest |=> invalid_opcode != op_accept)
        else $error("save or restore opcode left without one answer");
    AST_ONE_ANSWER: assert property (!(op_accept && invalid_opcode))
        else $error("accept and fault in one cycle");
    AST_HDR_HOLD: assert property (hdr_we && !hdr_ready |=> hdr_we && $stable(hdr_addr))
        else $error("header write dropped or moved before acceptance");
    AST_HDR_DESCEND: assert property (hdr_we && hdr_ready ##2 hdr_we
        |-> hdr_addr == $past(hdr_addr, 2) - 32'h4)
        else $error("header words not at descending offsets");
    AST_RESUME_PULSE: assert property (resume_valid |=> !resume_valid)
        else $error("resume strobe longer than one cycle");

    // Main scenarios reached
    cover property (op_accept);
    cover property (invalid_opcode);
    cover property (resume_valid);
endmodule : mgmt_unit_monitor

bind mgmt_unit mgmt_unit_monitor u_mon (.pclk, .presetn, .op_valid, .op_byte0, .op_byte1,
    .op_sreg, .privilege, .hdr_ready, .hdr_we, .hdr_addr, .invalid_opcode, .op_accept,
    .op_xfer_bits, .resume_valid);

// *** mgmt_chipset_model.sv ***
// Chipset model driving the active-low management interrupt pin
`timescale 1ns/10ps
module mgmt_chipset_model (
    input  wire logic pclk,
    output logic      mgmt_interrupt_pin_n
);
    // Pin rests high between events, as a pulled-up line would
    initial mgmt_interrupt_pin_n = 1'b1;

    // One falling edge per event, since the unit only sees edges
    task automatic fire(input int low_cycles);
        @(posedge pclk);
        mgmt_interrupt_pin_n <= 1'b0;
        repeat (low_cycles) @(posedge pclk);
        mgmt_interrupt_pin_n <= 1'b1;
    endtask : fire
endmodule : mgmt_chipset_model

// *** smm_state_save_and_instructions_tb.sv ***
// Self-checking bench for the management-mode unit
`timescale 1ns/10ps
module smm_state_save_and_instructions_tb;
    localparam logic [31:0] TOP = 32'h0010_2000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr, op_byte0, op_byte1;
    logic [31:0] pwdata, prdata, rd, hdr_addr, hdr_wdata, resume_ip;
    logic mgmt_interrupt_pin_n, internal_trap, op_valid, hdr_ready, hdr_we;
    logic invalid_opcode, op_accept, in_mgmt, resume_valid;
    logic [1:0]  privilege;
    logic [2:0]  op_sreg;
    logic [6:0]  op_xfer_bits;
    mgmt_pkg::trap_info_type  trap_in;
    mgmt_pkg::core_state_type core_in, resume_state;
    logic [31:0] exp_q[$];
    int fails, n_compared, hits;

    mgmt_unit uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mgmt_interrupt_pin_n, .internal_trap, .trap_in, .core_in,
        .privilege, .op_valid, .op_byte0, .op_byte1, .op_sreg, .hdr_ready, .hdr_we,
        .hdr_addr, .hdr_wdata, .invalid_opcode, .op_accept, .op_xfer_bits, .in_mgmt,
        .resume_valid, .resume_ip, .resume_state);
    mgmt_chipset_model chip (.pclk(pclk), .mgmt_interrupt_pin_n(mgmt_interrupt_pin_n));

    // Clock, 5 ns period
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Header memory stalls at random to exercise the hold
    always @(posedge pclk) hdr_ready <= 1'($urandom % 2);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1); // Watchdog ends a hang
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // Idle edge so a following call never reassigns psel at once
    endtask : apb

    // Two-byte opcode request and its answer one edge later
    task automatic op(input logic [7:0] b1, input logic [2:0] sr, input logic ok);
        logic acc;
        acc = ok && b1 != 8'haa && b1 != 8'h38; // Resume and entry answer by action only
        op_valid <= 1'b1;
        op_byte1 <= b1;
        op_sreg  <= sr;
        @(posedge pclk);
        op_valid <= 1'b0;
        @(posedge pclk);
        check({30'h0, op_accept, invalid_opcode}, {30'h0, acc, !ok});
        if (acc) check({25'h0, op_xfer_bits}, 32'h50);
    endtask : op

    // Fresh core and trap state; software entries carry no trap
    task automatic rnd(input logic sw, input logic [1:0] sz);
        mgmt_pkg::trap_info_type t;
        t = 119'({$urandom, $urandom, $urandom, $urandom});
        t.size = sz;
        core_in <= 242'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
                         $urandom, $urandom});
        trap_in <= sw ? '0 : t;
        @(posedge pclk);
    endtask : rnd

    // Reference header, top word first
    function automatic void expect_hdr(input logic sw, input logic ext);
        logic [15:0] sz;
        sz = trap_in.size == 2'h0 ? 16'h0001 : trap_in.size == 2'h1 ? 16'h0003 : 16'h000f;
        exp_q.push_back(core_in.debug7);
        exp_q.push_back(core_in.flags);
        exp_q.push_back(core_in.ctrl0);
        exp_q.push_back(core_in.cur_ip);
        exp_q.push_back(core_in.next_ip);
        exp_q.push_back({16'h0, core_in.cs_sel});
        exp_q.push_back(core_in.cs_desc[63:32]);
        exp_q.push_back(core_in.cs_desc[31:0]);
        exp_q.push_back({23'h0, 1'b0, trap_in.vga, ext, trap_in.is_memory, core_in.halted,
                         sw, trap_in.rep_prefix, trap_in.is_write, core_in.cs_writable});
        exp_q.push_back({sz, trap_in.io_port});
        exp_q.push_back(trap_in.data);
        exp_q.push_back(trap_in.index);
        exp_q.push_back(trap_in.mem_addr);
    endfunction : expect_hdr

    task automatic get_hdr();
        for (int i = 0; i < 13; i++) begin
            do @(posedge pclk); while (!(hdr_we === 1'b1 && hdr_ready === 1'b1));
            check(hdr_addr, TOP - 32'(4 * (i + 1)));
            check(hdr_wdata, exp_q.pop_front());
        end
        @(posedge pclk);
        check({31'h0, in_mgmt}, 32'h1);
    endtask : get_hdr

    task automatic do_resume();
        int n;
        n = 0;
        op(8'haa, 3'h0, 1'b1);
        while (resume_valid !== 1'b1 && n++ < 10) @(posedge pclk);
        check({31'h0, resume_valid}, 32'h1);
        check(resume_ip, core_in.next_ip);
        check(resume_state.ctrl0, core_in.ctrl0);
        @(posedge pclk); // A deferred entry may start writing right after this
    endtask : do_resume

    // Main sequence
    initial begin
        void'($urandom(41));
        {presetn, psel, penable, pwrite, paddr, pwdata, internal_trap} = '0;
        {op_valid, op_byte1, op_sreg, privilege, trap_in, core_in} = '0;
        op_byte0 = 8'h0f;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        op(8'h78, 3'h0, 1'b0);
        op(8'h38, 3'h0, 1'b0);
        apb(1'b1, 8'h00, 32'h3);
        op(8'h7c, 3'h0, 1'b0);
        apb(1'b1, 8'h20, 32'h0010_0001);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h3);
        for (int b = 8'h78; b <= 8'h7d; b++) begin
            privilege <= 2'h3;
            op(8'(b), 3'h0, 1'b0);
            privilege <= 2'h0;
            op(8'(b), 3'h3, 1'b1);
        end
        op(8'h79, 3'h1, 1'b0);
        privilege <= 2'h3;
        op(8'haa, 3'h0, 1'b0);
        op(8'h38, 3'h0, 1'b0);
        privilege <= 2'h0;
        rnd(1'b0, 2'h2);
        expect_hdr(1'b0, 1'b1);
        chip.fire(4);
        get_hdr();
        do_resume();
        // Software session holds off a pin event until resume
        rnd(1'b1, 2'h0);
        expect_hdr(1'b1, 1'b0);
        op(8'h38, 3'h0, 1'b1);
        get_hdr();
        expect_hdr(1'b0, 1'b1);
        chip.fire(4);
        hits = 0;
        repeat (30) begin
            @(posedge pclk);
            if (hdr_we !== 1'b0) hits++;
        end
        check(32'(hits), 32'h0);
        do_resume();
        get_hdr();
        do_resume();
        // Internal traps over every size code
        for (int k = 0; k < 4; k++) begin
            rnd(1'b0, 2'(k));
            expect_hdr(1'b0, 1'b0);
            internal_trap <= 1'b1;
            @(posedge pclk);
            internal_trap <= 1'b0;
            get_hdr();
            do_resume();
        end
        print_verdict();
    end

    // Watchdog well past the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        print_verdict();
    end
endmodule : smm_state_save_and_instructions_tb
